// ---- pkg/hpp_defines.vh ----
// Constants for the host parallel port: select levels, status fields, reset values, buffer geometry
`ifndef HPP_DEFINES_VH
`define HPP_DEFINES_VH
// Register select line level
`define HPP_SEL_STATUS 1'b1
`define HPP_SEL_DATA 1'b0
// Status register bit positions
`define HPP_ST_TX_FULL 0
`define HPP_ST_RX_FULL 1
`define HPP_ST_TX_IRQ_EN 2
`define HPP_ST_RX_IRQ_EN 3
`define HPP_ST_WIDE 4
`define HPP_ST_RX_COUNT_LO 5
`define HPP_ST_RX_COUNT_HI 6
// Reset values
`define HPP_STATUS_RESET 16'h0010
`define HPP_DATA_RESET 16'h0000
// Buffer geometry
`define HPP_DATA_W 16
`define HPP_BUF_DEPTH 2
`endif

// ---- verif/hpp_host_model.sv ----
// Host processor model driving the parallel port pins
`timescale 1ns/100ps
module hpp_host_model (
  // Clock
  input wire clk,
  // Port pins
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic sel,
  output logic lane,
  output logic [15:0] bus_in,
  input wire [15:0] bus_out,
  input wire bus_oe
);
  logic [15:0] drv = 16'h0000;
  logic drv_en = 1'b0;
  // Released bus floats to the pull-up level
  assign bus_in = bus_oe ? bus_out : (drv_en ? drv : 16'hffff);
  initial begin
    {cs_n, rd_n, wr_n, sel, lane} = 5'b11100;
  end
  task automatic access(input logic w, input logic s, input logic l, input logic [15:0] d,
    output logic [15:0] q);
    @(posedge clk);
    cs_n <= 1'b0;
    rd_n <= w;
    wr_n <= !w;
    sel <= s;
    lane <= l;
    drv <= d;
    drv_en <= w;
    repeat (6) @(posedge clk);
    q = bus_in;
    {cs_n, rd_n, wr_n} <= 3'b111;
    drv_en <= 1'b0;
    // Strobes stay high long enough for the synchroniser
    repeat (5) @(posedge clk);
  endtask
endmodule

// ---- verif/hpp_top_bench.sv ----
// Self-checking bench for the host parallel port
`timescale 1ns/100ps
module hpp_top_bench;
  logic clk, nrst, cs_n, rd_n, wr_n, sel, lane, oe, re, we, cwr, crd, txi, rxi;
  logic [1:0] ca;
  logic [15:0] bin, bout, wd, rdat, q, w0, w1;
  int failures = 0, n_compared = 0, cyc = 0, i;
  hpp_top hpp_top_i (.clk(clk), .nrst(nrst), .port_chip_select_n(cs_n), .host_read_strobe_n(rd_n),
    .host_write_strobe_n(wr_n), .register_select_line(sel), .byte_lane_select_line(lane),
    .host_data_bus_in(bin), .host_data_bus_out(bout), .host_data_bus_oe(oe), .read_enable_flag_out(re),
    .write_enable_flag_out(we), .core_addr(ca), .core_wdata(wd), .core_wr(cwr), .core_rd(crd),
    .core_rdata(rdat), .tx_empty_irq(txi), .rx_ready_irq(rxi));
  hpp_host_model hpp_host_model_i (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .sel(sel),
    .lane(lane), .bus_in(bin), .bus_out(bout), .bus_oe(oe));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [15:0] stat(logic [2:0] c, logic t, logic [1:0] n);
    return {9'h000, n, c, n != 2'h0, t};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic creg(input logic w, input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    ca <= a;
    wd <= d;
    cwr <= w;
    crd <= !w;
    @(posedge clk);
    cwr <= 1'b0;
    crd <= 1'b0;
    #1;
  endtask
  task automatic acc(input logic w, input logic s, input logic l, input logic [15:0] d);
    hpp_host_model_i.access(w, s, l, d, q);
  endtask
  task automatic complete_run;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      complete_run;
    end
  end
  initial begin
    {cwr, crd, nrst, ca, wd} = 21'h0;
    void'($urandom(32'h4e45));
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check({13'h0, oe, re, we}, 16'h0001);
    acc(0, 1, 0, 0);
    check(q, stat(3'b100, 0, 0));
    for (i = 0; i < 4; i++) begin
      w0 = 16'($urandom);
      w1 = 16'($urandom);
      creg(1, 2'h0, w0);
      repeat (2) @(posedge clk);
      #1;
      check({15'h0, re}, 16'h1);
      acc(0, 0, i[0], 0);
      check(q, w0);
      check({15'h0, re}, 16'h0);
      acc(1, 0, i[1], w1);
      creg(0, 2'h1, 0);
      check(rdat, w1);
    end
    // Byte lanes with receive irq enabled
    creg(1, 2'h2, 16'h0008);
    creg(0, 2'h2, 0);
    check(rdat & 16'h001c, 16'h0008);
    acc(1, 0, 0, {8'h00, w1[7:0]});
    acc(1, 0, 1, {8'h00, w1[15:8]});
    check({15'h0, rxi}, 16'h1);
    creg(0, 2'h1, 0);
    check(rdat, w1);
    creg(1, 2'h0, w0);
    acc(0, 1, 0, 0);
    check(q, stat(3'b010, 1, 0));
    acc(0, 1, 1, 0);
    check(q, 16'h0000);
    acc(0, 0, 0, 0);
    check(q & 16'h00ff, {8'h00, w0[7:0]});
    acc(0, 0, 1, 0);
    check(q & 16'h00ff, {8'h00, w0[15:8]});
    // Overfill: third word must be dropped
    creg(1, 2'h2, 16'h0010);
    acc(1, 0, 0, w0);
    acc(1, 0, 0, w1);
    acc(1, 0, 0, 16'h5a5a);
    check({15'h0, we}, 16'h0);
    acc(0, 1, 0, 0);
    check(q, stat(3'b100, 0, 2'h2));
    creg(0, 2'h1, 0);
    check(rdat, w0);
    creg(0, 2'h1, 0);
    check(rdat, w1);
    repeat (2) @(posedge clk);
    #1;
    check({15'h0, we}, 16'h1);
    creg(0, 2'h1, 0);
    check(rdat, w1);
    creg(1, 2'h2, 16'h0014);
    repeat (2) @(posedge clk);
    #1;
    check({15'h0, txi}, 16'h1);
    complete_run;
  end
endmodule

// ---- verif/hpp_top_props.sv ----
// Assertion checker for the host parallel port
`timescale 1ns/100ps
module hpp_top_props (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Host side
  input wire port_chip_select_n,
  input wire host_read_strobe_n,
  input wire host_write_strobe_n,
  input wire [15:0] host_data_bus_out,
  input wire host_data_bus_oe,
  input wire read_enable_flag_out,
  input wire write_enable_flag_out,
  // Core side
  input wire [1:0] core_addr,
  input wire [15:0] core_wdata,
  input wire core_wr,
  input wire core_rd,
  input wire [15:0] core_rdata,
  input wire tx_empty_irq,
  input wire rx_ready_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire tx_wr = core_wr && core_addr == 2'h0;
  wire ctl_wr = core_wr && core_addr == 2'h2;
  wire rx_pop = core_rd && core_addr == 2'h1;
  property p_oe_cause;
    host_data_bus_oe |-> $past(!port_chip_select_n && !host_read_strobe_n, 3);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("bus driven outside read");
  property p_oe_write;
    !host_write_strobe_n |-> !host_data_bus_oe;
  endproperty
  a_oe_write: assert property (p_oe_write) else $error("bus driven in write");
  property p_data_hold;
    host_data_bus_oe && $past(host_data_bus_oe) |-> $stable(host_data_bus_out);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("read data moved");
  property p_re_set;
    tx_wr |-> ##2 read_enable_flag_out;
  endproperty
  a_re_set: assert property (p_re_set) else $error("read enable late");
  property p_re_rise;
    $rose(read_enable_flag_out) |-> $past(tx_wr, 2);
  endproperty
  a_re_rise: assert property (p_re_rise) else $error("read enable without word");
  property p_we_rise;
    $rose(write_enable_flag_out) |-> $past(rx_pop) || $past(rx_pop, 2) || $past(!nrst, 2);
  endproperty
  a_we_rise: assert property (p_we_rise) else $error("write enable without room");
  property p_irq_mask;
    ctl_wr && core_wdata[3:2] == 2'b00 |-> ##2 !tx_empty_irq && !rx_ready_irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq seen");
  property p_ctl_back;
    ctl_wr ##2 core_rd && core_addr == 2'h2 |=> core_rdata[4:2] == $past(core_wdata[4:2], 3);
  endproperty
  a_ctl_back: assert property (p_ctl_back) else $error("control readback");
  c_read: cover property (host_data_bus_oe);
  c_rx_irq: cover property (rx_ready_irq);
  c_full: cover property ($fell(write_enable_flag_out));
endmodule
bind hpp_top hpp_top_props hpp_top_props_i (.clk(clk), .nrst(nrst), .port_chip_select_n(port_chip_select_n),
  .host_read_strobe_n(host_read_strobe_n), .host_write_strobe_n(host_write_strobe_n),
  .host_data_bus_out(host_data_bus_out), .host_data_bus_oe(host_data_bus_oe),
  .read_enable_flag_out(read_enable_flag_out), .write_enable_flag_out(write_enable_flag_out),
  .core_addr(core_addr), .core_wdata(core_wdata), .core_wr(core_wr), .core_rd(core_rd),
  .core_rdata(core_rdata), .tx_empty_irq(tx_empty_irq), .rx_ready_irq(rx_ready_irq));

// ---- verilog/hpp_buffer.v ----
// Two-entry valid/ready buffer for host-written words
`timescale 1ns/100ps
`include "hpp_defines.vh"
module hpp_buffer (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Fill side
  input wire in_valid,
  input wire [`HPP_DATA_W-1:0] in_data,
  output wire in_ready,
  // Drain side
  output wire out_valid,
  output wire [`HPP_DATA_W-1:0] out_data,
  input wire out_ready,
  // Occupancy
  output wire [1:0] count
);
  reg [`HPP_DATA_W-1:0] mem [0:`HPP_BUF_DEPTH-1];
  reg rd_ptr;
  reg wr_ptr;
  reg [1:0] fill;
  wire push;
  wire pop;
  integer i;

  assign in_ready = (fill != 2'd2);
  assign out_valid = (fill != 2'd0);
  assign out_data = mem[rd_ptr];
  assign count = fill;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge clk) begin
    if (!nrst) begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      fill <= 2'd0;
      for (i = 0; i < `HPP_BUF_DEPTH; i = i + 1) begin
        mem[i] <= `HPP_DATA_RESET;
      end
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (push && !pop) begin
        fill <= fill + 2'd1;
      end else if (pop && !push) begin
        fill <= fill - 2'd1;
      end
    end
  end
endmodule

// ---- verilog/hpp_top.v ----
// Host parallel port: host pins, transmit and receive data registers, status
`timescale 1ns/100ps
`include "hpp_defines.vh"
module hpp_top (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Host pins
  input wire port_chip_select_n,
  input wire host_read_strobe_n,
  input wire host_write_strobe_n,
  input wire register_select_line,
  input wire byte_lane_select_line,
  input wire [15:0] host_data_bus_in,
  output reg [15:0] host_data_bus_out,
  output reg host_data_bus_oe,
  output reg read_enable_flag_out,
  output reg write_enable_flag_out,
  // Core register port
  input wire [1:0] core_addr,
  input wire [15:0] core_wdata,
  input wire core_wr,
  input wire core_rd,
  output reg [15:0] core_rdata,
  // Core interrupt requests
  output reg tx_empty_irq,
  output reg rx_ready_irq
);
  // Core register indices
  localparam [1:0] CORE_TX = 2'h0;
  localparam [1:0] CORE_RX = 2'h1;
  localparam [1:0] CORE_CTRL = 2'h2;
  localparam [1:0] CORE_STAT = 2'h3;
  // Host access states
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_READ = 2'b01;
  localparam [1:0] ST_WRITE = 2'b10;
  // Reset image of the status word, for the mode bit
  localparam [15:0] STATUS_RST = `HPP_STATUS_RESET;

  // Two-flop synchronisers for all host pins
  reg [21:0] sync1;
  reg [21:0] sync2;
  wire cs_s = ~sync2[0];
  wire rd_s = ~sync2[1];
  wire wr_s = ~sync2[2];
  wire sel_s = sync2[3];
  wire lane_s = sync2[4];
  wire [15:0] hdin_s = sync2[20:5];

  reg [1:0] state;
  reg [15:0] transmit_data_register;
  reg tx_full;
  reg [15:0] receive_data_register;
  reg wide_mode;
  reg tx_irq_en;
  reg rx_irq_en;
  reg rx_lo_held;
  reg [7:0] rx_lo_byte;
  reg [15:0] next_core_rdata;

  wire buf_in_ready;
  wire buf_out_valid;
  wire [15:0] buf_out_data;
  wire [1:0] buf_count;
  reg buf_push;
  reg [15:0] buf_word;
  wire buf_pop = core_rd && (core_addr == CORE_RX);

  wire [15:0] port_status_register = {9'h000, buf_count, wide_mode, rx_irq_en, tx_irq_en, buf_out_valid, tx_full};

  // Lane select for an 8-bit read
  function [15:0] lane_pick;
    input [15:0] word;
    input lane;
    input wide;
    begin
      if (wide) begin
        lane_pick = word;
      end else if (lane) begin
        lane_pick = {8'h00, word[15:8]};
      end else begin
        lane_pick = {8'h00, word[7:0]};
      end
    end
  endfunction

  hpp_buffer u_buf (
    .clk(clk),
    .nrst(nrst),
    .in_valid(buf_push),
    .in_data(buf_word),
    .in_ready(buf_in_ready),
    .out_valid(buf_out_valid),
    .out_data(buf_out_data),
    .out_ready(buf_pop),
    .count(buf_count)
  );

  always @(posedge clk) begin
    if (!nrst) begin
      sync1 <= 22'h3fffff;
      sync2 <= 22'h3fffff;
    end else begin
      sync1 <= {1'b1, host_data_bus_in, byte_lane_select_line, register_select_line,
                host_write_strobe_n, host_read_strobe_n, port_chip_select_n};
      sync2 <= sync1;
    end
  end

  always @* begin
    case (core_addr)
      CORE_TX: next_core_rdata = transmit_data_register;
      CORE_RX: next_core_rdata = buf_out_valid ? buf_out_data : receive_data_register;
      CORE_CTRL: next_core_rdata = {11'h000, wide_mode, rx_irq_en, tx_irq_en, 2'b00};
      CORE_STAT: next_core_rdata = port_status_register;
      default: next_core_rdata = 16'h0000;
    endcase
  end

  always @(posedge clk) begin
    if (!nrst) begin
      state <= ST_IDLE;
      transmit_data_register <= `HPP_DATA_RESET;
      receive_data_register <= `HPP_DATA_RESET;
      tx_full <= 1'b0;
      wide_mode <= STATUS_RST[`HPP_ST_WIDE];
      tx_irq_en <= 1'b0;
      rx_irq_en <= 1'b0;
      rx_lo_held <= 1'b0;
      rx_lo_byte <= 8'h00;
      buf_push <= 1'b0;
      buf_word <= 16'h0000;
      host_data_bus_out <= 16'h0000;
      host_data_bus_oe <= 1'b0;
      read_enable_flag_out <= 1'b0;
      write_enable_flag_out <= 1'b0;
      core_rdata <= 16'h0000;
      tx_empty_irq <= 1'b0;
      rx_ready_irq <= 1'b0;
    end else begin
      buf_push <= 1'b0;
      if (core_rd) begin
        core_rdata <= next_core_rdata;
      end
      if (buf_pop && buf_out_valid) begin
        receive_data_register <= buf_out_data;
      end
      if (core_wr && core_addr == CORE_CTRL) begin
        tx_irq_en <= core_wdata[`HPP_ST_TX_IRQ_EN];
        rx_irq_en <= core_wdata[`HPP_ST_RX_IRQ_EN];
        wide_mode <= core_wdata[`HPP_ST_WIDE];
      end
      case (state)
        ST_IDLE: begin
          if (cs_s && rd_s) begin
            state <= ST_READ;
            host_data_bus_oe <= 1'b1;
            if (sel_s == `HPP_SEL_STATUS) begin
              host_data_bus_out <= lane_pick(port_status_register, lane_s, wide_mode);
            end else begin
              host_data_bus_out <= lane_pick(transmit_data_register, lane_s, wide_mode);
            end
          end else if (cs_s && wr_s) begin
            state <= ST_WRITE;
            // Write into receive path, status is read-only to the host
            if (sel_s == `HPP_SEL_DATA) begin
              if (wide_mode) begin
                buf_word <= hdin_s;
                buf_push <= buf_in_ready;
              end else if (!lane_s) begin
                rx_lo_byte <= hdin_s[7:0];
                rx_lo_held <= 1'b1;
              end else begin
                // High byte completes the word
                buf_word <= {hdin_s[7:0], rx_lo_held ? rx_lo_byte : 8'h00};
                buf_push <= buf_in_ready;
                rx_lo_held <= 1'b0;
              end
            end
          end
        end
        ST_READ: begin
          // Drivers off at end of access
          if (!(cs_s && rd_s)) begin
            state <= ST_IDLE;
            host_data_bus_oe <= 1'b0;
            if (sel_s == `HPP_SEL_DATA) begin
              // Word consumed on full read or on the high byte in 8-bit mode
              if (wide_mode || lane_s) begin
                tx_full <= 1'b0;
              end
            end
          end
        end
        ST_WRITE: begin
          if (!(cs_s && wr_s)) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
          host_data_bus_oe <= 1'b0;
        end
      endcase
      // Core write wins over a host read ending in the same cycle
      if (core_wr && core_addr == CORE_TX) begin
        transmit_data_register <= core_wdata;
        tx_full <= 1'b1;
      end
      read_enable_flag_out <= tx_full;
      write_enable_flag_out <= buf_in_ready;
      tx_empty_irq <= tx_irq_en && !tx_full;
      rx_ready_irq <= rx_irq_en && buf_out_valid;
    end
  end
endmodule
